// ==== src/bmo_data_memory.v ====
// banked data memory map: bank decode, mirrors, general purpose storage, program fetch
`include "bmo_map.vh"
module bmo_data_memory (
	input wire ref_clk,
	input wire reset_n,
	input wire pc_advance,
	input wire pc_load,
	input wire [12:0] pc_load_value,
	input wire int_take,
	output wire [12:0] pc,
	input wire [13:0] prog_rdata,
	output reg [13:0] insn,
	input wire bank_select_low,
	input wire bank_select_high,
	input wire bank_select_ind,
	input wire [6:0] data_offset,
	input wire data_wr,
	input wire data_rd,
	input wire [7:0] data_wdata,
	output reg [7:0] data_rdata,
	output reg [8:0] data_addr,
	output reg sfr_sel,
	output reg [8:0] sfr_addr,
	output reg [7:0] indirect_pointer
);
	reg [7:0] gpr_mem [0:`BMO_GPR_DEPTH-1];
	reg [8:0] raw_addr;
	reg [8:0] eff_addr;
	reg [8:0] gpr_idx;
	reg gpr_hit;
	reg is_sfr;
	reg [8:0] sfr_phys;
	reg use_ind;
	reg ptr_hit;
	reg access;

	bmo_prog_counter u_pc (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pc_advance(pc_advance),
		.pc_load(pc_load),
		.pc_load_value(pc_load_value),
		.int_take(int_take),
		.pc(pc)
	);

	// offsets that every bank shares with bank 0
	function core_mirror;
		input [6:0] o;
		begin
			core_mirror = 1'b0;
			if (o == `BMO_IND_OFS || o == `BMO_PC_LOW_OFS || o == `BMO_FLAGS_OFS) begin
				core_mirror = 1'b1;
			end
			if (o == `BMO_PTR_OFS || o == `BMO_PC_HIGH_OFS || o == `BMO_INT_CTRL_OFS) begin
				core_mirror = 1'b1;
			end
		end
	endfunction

	// offsets that banks 2 and 3 share with banks 0 and 1
	function pair_mirror;
		input [6:0] o;
		begin
			pair_mirror = 1'b0;
			if (o == `BMO_PAIR_OFS) begin
				pair_mirror = 1'b1;
			end
			if (o >= `BMO_PAIR_LO && o <= `BMO_PAIR_HI) begin
				pair_mirror = 1'b1;
			end
		end
	endfunction

	// common area at the top of every bank
	function common_area;
		input [6:0] o;
		begin
			common_area = (o >= `BMO_COMMON_LO);
		end
	endfunction

	// fold mirrored locations onto their one physical address
	function [8:0] mirror_fold;
		input [8:0] a;
		reg [6:0] o;
		begin
			o = a[6:0];
			mirror_fold = a;
			if (core_mirror(o) || common_area(o)) begin
				mirror_fold = {2'b00, o}; // RL6
			end else if (pair_mirror(o) && a[8]) begin
				mirror_fold = {1'b0, a[7], o}; // RL6
			end
		end
	endfunction

	// storage index of offset o in a window that starts at lo, msb marks a hit
	function [9:0] gpr_slot;
		input [8:0] base;
		input [6:0] o;
		input [6:0] lo;
		reg [6:0] rel;
		begin
			rel = o - lo;
			gpr_slot = {1'b1, base + {2'b00, rel}};
		end
	endfunction

	// map an address onto a general purpose storage index
	function [9:0] gpr_map;
		input [8:0] a;
		reg [6:0] o;
		begin
			o = a[6:0];
			gpr_map = 10'h000;
			if (common_area(o)) begin
				gpr_map = gpr_slot(`BMO_GPR_BASE_B0, o, `BMO_B0_GPR_LO); // RL6
			end else begin
				case (a[8:7])
					`BMO_BANK0: begin
						if (o >= `BMO_B0_GPR_LO) begin
							gpr_map = gpr_slot(`BMO_GPR_BASE_B0, o, `BMO_B0_GPR_LO);
						end
					end
					`BMO_BANK1: begin
						if (o >= `BMO_B12_GPR_LO && o <= `BMO_B12_GPR_HI) begin
							gpr_map = gpr_slot(`BMO_GPR_BASE_B1, o, `BMO_B12_GPR_LO);
						end
					end
					`BMO_BANK2: begin
						if (o >= `BMO_B12_GPR_LO && o <= `BMO_B12_GPR_HI) begin
							gpr_map = gpr_slot(`BMO_GPR_BASE_B2, o, `BMO_B12_GPR_LO);
						end else if (o >= `BMO_B2_GPR_LO && o <= `BMO_B2_GPR_HI) begin
							gpr_map = gpr_slot(`BMO_GPR_BASE_B2L, o, `BMO_B2_GPR_LO);
						end
					end
					`BMO_BANK3: begin
						if (o >= `BMO_B12_GPR_LO && o <= `BMO_B12_GPR_HI) begin
							gpr_map = gpr_slot(`BMO_GPR_BASE_B3, o, `BMO_B12_GPR_LO);
						end else if (o >= `BMO_B3_GPR_LO && o <= `BMO_B3_GPR_HI) begin
							gpr_map = gpr_slot(`BMO_GPR_BASE_B3L, o, `BMO_B3_GPR_LO);
						end
					end
					default: begin
						gpr_map = 10'h000;
					end
				endcase
			end
		end
	endfunction

	// implemented special function register slots of each bank
	function sfr_impl;
		input [8:0] a;
		reg [6:0] o;
		begin
			o = a[6:0];
			sfr_impl = (o <= `BMO_SFR_TOP);
			if (a[8:7] == `BMO_BANK2 && o >= `BMO_B2_GPR_LO) begin
				sfr_impl = 1'b0;
			end
			if (a[8:7] == `BMO_BANK3 && o >= `BMO_B3_RSV_LO) begin
				sfr_impl = 1'b0;
			end
			if (o == `BMO_IND_OFS) begin
				sfr_impl = 1'b0;
			end
		end
	endfunction

	// address decode for the access presented this cycle
	always @* begin
		use_ind = (data_offset == `BMO_IND_OFS);
		raw_addr = {bank_select_high, bank_select_low, data_offset}; // RL3 RL10
		if (use_ind) begin
			raw_addr = {bank_select_ind, indirect_pointer}; // RL8
		end
		eff_addr = mirror_fold(raw_addr); // RL10
		{gpr_hit, gpr_idx} = gpr_map(raw_addr); // RL4 RL7
		is_sfr = !gpr_hit && sfr_impl(raw_addr);
		sfr_phys = eff_addr;
		ptr_hit = is_sfr && (sfr_phys == {2'b00, `BMO_PTR_OFS});
		access = data_wr || data_rd;
	end

	// static storage, no reset so contents survive a core reset
	always @(posedge ref_clk) begin
		if (data_wr && gpr_hit) begin
			gpr_mem[gpr_idx] <= data_wdata; // RL5
		end
	end

	// instruction word follows the fetch address by one edge
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			insn <= 14'h0000;
		end else begin
			insn <= prog_rdata; // RL1
		end
	end

	// resolved address and special register select for the core
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			data_addr <= 9'h000;
			sfr_sel <= 1'b0;
			sfr_addr <= 9'h000;
		end else begin
			data_addr <= eff_addr; // RL10
			sfr_sel <= is_sfr && access;
			sfr_addr <= sfr_phys; // RL6
		end
	end

	// indirect pointer, reachable from any bank
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			indirect_pointer <= `BMO_PTR_RST;
		end else if (data_wr && ptr_hit) begin
			indirect_pointer <= data_wdata; // RL8
		end
	end

	// read data holds until the next read
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			data_rdata <= 8'h00;
		end else if (data_rd) begin
			if (gpr_hit) begin
				data_rdata <= gpr_mem[gpr_idx]; // RL5
			end else if (ptr_hit) begin
				data_rdata <= indirect_pointer; // RL8
			end else begin
				data_rdata <= `BMO_UNIMPL_DATA; // RL9
			end
		end
	end
endmodule

// ==== src/bmo_map.vh ====
// address map constants for the banked memory organization block
// Summary of operation
// RL1 - A 13-bit program counter addresses an 8K by 14-bit program memory.
// RL2 - Reset starts fetching at address 0000h and an interrupt loads address 0004h.
// RL3 - Two bank select bits pick data bank 0 to 3, the high bit being the most significant.
// RL4 - Each bank spans offsets 00h to 7Fh, special function registers low and general purpose registers above.
// RL5 - General purpose registers are static storage holding the last value written.
// RL6 - Frequently used special function registers are mirrored so several banks reach one physical register.
// RL7 - The general purpose register file holds 363 locations of 8 bits.
// RL8 - Every register file location is reachable directly or through the indirect pointer.
// RL9 - A read of an unimplemented data location returns zero.
// RL10 - A direct address is the bank select bits above the 7-bit offset, with mirrors folded to one register.
`ifndef BMO_MAP_VH
`define BMO_MAP_VH
`define BMO_PC_W 13
`define BMO_INSN_W 14
`define BMO_RESET_VEC 13'h0000
`define BMO_INT_VEC 13'h0004
`define BMO_DADDR_W 9
`define BMO_OFS_W 7
`define BMO_GPR_DEPTH 363
`define BMO_GPR_IDX_W 9
`define BMO_IND_OFS 7'h00
`define BMO_PTR_OFS 7'h04
`define BMO_SFR_TOP 7'h1f
`define BMO_COMMON_LO 7'h70
`define BMO_B0_GPR_LO 7'h20
`define BMO_B12_GPR_LO 7'h20
`define BMO_B12_GPR_HI 7'h6f
`define BMO_B2_GPR_LO 7'h15
`define BMO_B2_GPR_HI 7'h1f
`define BMO_B3_GPR_LO 7'h10
`define BMO_B3_GPR_HI 7'h1f
`define BMO_GPR_BASE_B0 9'h000
`define BMO_GPR_BASE_B1 9'h060
`define BMO_GPR_BASE_B2 9'h0b0
`define BMO_GPR_BASE_B2L 9'h100
`define BMO_GPR_BASE_B3 9'h10b
`define BMO_GPR_BASE_B3L 9'h15b
`define BMO_BANK0 2'b00
`define BMO_BANK1 2'b01
`define BMO_BANK2 2'b10
`define BMO_BANK3 2'b11
`define BMO_PC_LOW_OFS 7'h02
`define BMO_FLAGS_OFS 7'h03
`define BMO_PC_HIGH_OFS 7'h0a
`define BMO_INT_CTRL_OFS 7'h0b
`define BMO_PAIR_OFS 7'h01
`define BMO_PAIR_LO 7'h05
`define BMO_PAIR_HI 7'h09
`define BMO_B3_RSV_LO 7'h0d
`define BMO_PTR_RST 8'h00
`define BMO_UNIMPL_DATA 8'h00
`endif

// ==== src/bmo_prog_counter.v ====
// program counter with reset and interrupt vectors
`include "bmo_map.vh"
module bmo_prog_counter (
	input wire ref_clk,
	input wire reset_n,
	input wire pc_advance,
	input wire pc_load,
	input wire [`BMO_PC_W-1:0] pc_load_value,
	input wire int_take,
	output reg [`BMO_PC_W-1:0] pc
);
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pc <= `BMO_RESET_VEC; // RL2
		end else if (int_take) begin
			pc <= `BMO_INT_VEC; // RL2
		end else if (pc_load) begin
			pc <= pc_load_value;
		end else if (pc_advance) begin
			pc <= pc + 13'h0001; // RL1
		end
	end
endmodule

// ==== testbench/banked_memory_organization_tb_top.sv ====
// bench for the banked memory block
module banked_memory_organization_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, reset_n = 0, pc_advance = 0, pc_load = 0, int_take = 0, data_wr = 0, data_rd = 0, sfr_sel;
	logic bank_select_low = 0, bank_select_high = 0, bank_select_ind = 0;
	logic [12:0] pc_load_value = 0, pc;
	logic [13:0] prog_rdata, insn;
	logic [6:0] data_offset = 0;
	logic [7:0] data_wdata = 0, data_rdata, indirect_pointer;
	logic [8:0] data_addr, sfr_addr;
	int n_mismatch = 0, comparisons = 0;
	bmo_data_memory u_bmo_data_memory (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pc_advance(pc_advance),
		.pc_load(pc_load),
		.pc_load_value(pc_load_value),
		.int_take(int_take),
		.pc(pc),
		.prog_rdata(prog_rdata),
		.insn(insn),
		.bank_select_low(bank_select_low),
		.bank_select_high(bank_select_high),
		.bank_select_ind(bank_select_ind),
		.data_offset(data_offset),
		.data_wr(data_wr),
		.data_rd(data_rd),
		.data_wdata(data_wdata),
		.data_rdata(data_rdata),
		.data_addr(data_addr),
		.sfr_sel(sfr_sel),
		.sfr_addr(sfr_addr),
		.indirect_pointer(indirect_pointer)
	);
	bmo_prog_rom u_bmo_prog_rom (
		.pc(pc),
		.prog_rdata(prog_rdata)
	);
	initial forever #10 ref_clk = ~ref_clk;
	task automatic chk(logic [13:0] s, logic [13:0] e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %0t saw %h want %h", $time, s, e);
		end
	endtask
	// p is advance, load, interrupt, load value
	task automatic step(logic [15:0] p, logic [1:0] w, logic [2:0] b, logic [6:0] o, logic [7:0] d);
		{pc_advance, pc_load, int_take, pc_load_value, data_wr, data_rd} = {p, w};
		{bank_select_ind, bank_select_high, bank_select_low, data_offset, data_wdata} = {b, o, d};
		@(negedge ref_clk);
	endtask
	task automatic wr_rd(logic [2:0] wb, logic [6:0] wo, logic [2:0] rb, logic [6:0] ro, logic [7:0] d, e);
		step(0, 2'h2, wb, wo, d);
		step(0, 2'h1, rb, ro, 0);
		chk(data_rdata, e);
	endtask
	task automatic t_pc;
		chk(pc, 0);
		step(16'h8000, 0, 0, 0, 0);
		chk(insn, 14'h1);
		step(16'h5fff, 0, 0, 0, 0);
		step(16'h8000, 0, 0, 0, 0);
		chk(pc, 0);
		chk(insn, 14'h3fff);
		step(16'he100, 0, 0, 0, 0);
		chk(pc, 13'h4);
	endtask
	task automatic t_mem;
		for (int b = 0; b < 4; b++) wr_rd(b[2:0], 7'h25, b[2:0], 7'h25, 8'ha0 + b[7:0], 8'ha0 + b[7:0]);
		wr_rd(3'h3, 7'hd, 3'h0, 7'h25, 8'h11, 8'ha0);
		wr_rd(3'h3, 7'h10, 3'h3, 7'h10, 8'hc3, 8'hc3);
		wr_rd(3'h3, 7'h7e, 3'h3, 7'hd, 8'h3c, 8'h0);
		wr_rd(3'h1, 7'h4, 3'h0, 7'h7e, 8'h30, 8'h3c);
		wr_rd(3'h4, 7'h0, 3'h2, 7'h30, 8'h77, 8'h77);
	endtask
	task automatic t_sfr;
		step(0, 2'h1, 3'h3, 7'h2, 0);
		chk(sfr_sel, 1);
		chk(sfr_addr, 9'h002);
		step(0, 2'h1, 3'h3, 7'h6, 0);
		chk(sfr_addr, 9'h086);
		step(0, 2'h1, 3'h3, 7'h7e, 0);
		chk(data_addr, 9'h07e);
		chk(data_rdata, 8'h3c);
		step(0, 2'h1, 3'h1, 7'h25, 0);
		chk(data_addr, 9'h0a5);
		chk(sfr_sel, 0);
		chk(data_rdata, 8'ha1);
		step(0, 2'h1, 3'h2, 7'h4, 0);
		chk(data_rdata, 8'h30);
		chk(indirect_pointer, 8'h30);
	endtask
	task automatic t_reset;
		reset_n = 0;
		@(negedge ref_clk);
		chk(pc, 0);
		chk(indirect_pointer, 0);
		reset_n = 1;
		step(0, 2'h1, 3'h2, 7'h30, 0);
		chk(data_rdata, 8'h77);
		chk(pc, 0);
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#5us;
		n_mismatch++;
		test_done;
	end
	initial begin
		repeat (20) @(negedge ref_clk);
		reset_n = 1;
		@(negedge ref_clk);
		t_pc;
		t_mem;
		t_sfr;
		t_reset;
		test_done;
	end
endmodule

// ==== testbench/bmo_assertions.sv ====
// port checker for the banked memory block
module bmo_assertions (
	input logic ref_clk,
	input logic reset_n,
	input logic pc_advance,
	input logic pc_load,
	input logic int_take,
	input logic [12:0] pc,
	input logic bank_select_low,
	input logic bank_select_high,
	input logic [6:0] data_offset,
	input logic data_wr,
	input logic data_rd,
	input logic [7:0] data_wdata,
	input logic [7:0] data_rdata,
	input logic [8:0] data_addr,
	input logic [7:0] indirect_pointer,
	input logic sfr_sel,
	input logic [8:0] sfr_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	property p_int; int_take |=> pc == 13'h4; endproperty
	a_int: assert property (p_int) else $error("int vector");
	property p_adv; pc_advance && !pc_load && !int_take |=> pc == $past(pc) + 13'h1; endproperty
	a_adv: assert property (p_adv) else $error("pc step");
	property p_hold; !data_rd |=> $stable(data_rdata); endproperty
	a_hold: assert property (p_hold) else $error("rdata moved");
	property p_ptr; data_wr && data_offset == 7'h4 |=> indirect_pointer == $past(data_wdata); endproperty
	a_ptr: assert property (p_ptr) else $error("pointer");
	property p_zero; data_rd && bank_select_high && bank_select_low && data_offset == 7'hd |=> data_rdata == 8'h00; endproperty
	a_zero: assert property (p_zero) else $error("not zero");
	property p_bank; data_wr && data_offset == 7'h25
		|=> data_addr[8:7] == $past({bank_select_high, bank_select_low}); endproperty
	a_bank: assert property (p_bank) else $error("bank");
	property p_mir; data_wr && data_offset[6:4] == 3'h7 |=> data_addr[8:7] == 2'h0; endproperty
	a_mir: assert property (p_mir) else $error("mirror");
	property p_sfr; data_rd && bank_select_high && bank_select_low && data_offset == 7'h2
		|=> sfr_sel && sfr_addr == 9'h002; endproperty
	a_sfr: assert property (p_sfr) else $error("special register fold");
	sequence s_store;
		data_wr && !data_rd && data_offset == 7'h25;
	endsequence
	sequence s_fetch_back;
		data_rd && data_offset == 7'h25 && $stable({bank_select_high, bank_select_low});
	endsequence
	property p_store; s_store ##1 s_fetch_back |=> data_rdata == $past(data_wdata, 2); endproperty
	a_store: assert property (p_store) else $error("stored byte");
endmodule
bind bmo_data_memory bmo_assertions u_bmo_assertions (
	.ref_clk(ref_clk),
	.reset_n(reset_n),
	.pc_advance(pc_advance),
	.pc_load(pc_load),
	.int_take(int_take),
	.pc(pc),
	.bank_select_low(bank_select_low),
	.bank_select_high(bank_select_high),
	.data_offset(data_offset),
	.data_wr(data_wr),
	.data_rd(data_rd),
	.data_wdata(data_wdata),
	.data_rdata(data_rdata),
	.data_addr(data_addr),
	.indirect_pointer(indirect_pointer),
	.sfr_sel(sfr_sel),
	.sfr_addr(sfr_addr)
);

// ==== testbench/bmo_prog_rom.sv ====
// program memory model
module bmo_prog_rom (
	input logic [12:0] pc,
	output logic [13:0] prog_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	assign prog_rdata = {pc, 1'b1};
endmodule
